// [core/pll_fb_pkg.sv]
// shared constants and types for the feedback divider register slice
package pll_fb_pkg;

	// bank count and widths
	localparam int NUM_BANKS = 2;
	localparam int BANK_W    = 1;
	localparam int BYTE_W    = 8;
	localparam int WORD_W    = 32;
	localparam int FRAC_BITS = 66;
	localparam int INT_BITS  = 9;
	localparam int RATIO_W   = INT_BITS + FRAC_BITS;
	localparam int CNT_W     = 7;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_DEN_B0 = 6'h2c;
	localparam logic [5:0] IDX_DEN_B1 = 6'h2d;
	localparam logic [5:0] IDX_DEN_B2 = 6'h2e;
	localparam logic [5:0] IDX_DEN_B3 = 6'h2f;
	localparam logic [5:0] IDX_REM_B0 = 6'h30;
	localparam logic [5:0] IDX_REM_B1 = 6'h31;
	localparam logic [5:0] IDX_REM_B2 = 6'h32;
	localparam logic [5:0] IDX_REM_B3 = 6'h33;
	localparam logic [5:0] IDX_TRUNC  = 6'h34;
	localparam logic [5:0] IDX_BANK   = 6'h38;
	localparam logic [5:0] IDX_STATUS = 6'h39;

	// reset values
	localparam logic [7:0]        RST_BYTE  = 8'h00;
	localparam logic [BANK_W-1:0] RST_BANK  = 1'h0;
	localparam logic [31:0]       RST_WORD  = 32'h0000_0000;

	// status field positions
	localparam int ST_VALID   = 0;
	localparam int ST_DENZERO = 1;
	localparam int ST_BUSY    = 2;

	// bus encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic       HRESP_OKAY = 1'h0;

	// register identity after decode
	typedef enum logic [2:0] {
		REG_NONE, REG_DEN, REG_REM, REG_TRUNC, REG_BANK, REG_STATUS
	} reg_id_t;

	// divider sequencer, gray along idle-run-done
	typedef enum logic [1:0] {
		DIV_IDLE = 2'b00,
		DIV_RUN  = 2'b01,
		DIV_DONE = 2'b11
	} div_state_t;

endpackage

// [core/fb_ratio_divider.sv]
// serial divider forming the truncated feedback ratio of one bank
`timescale 1ns/1ps
`default_nettype none
module fb_ratio_divider
	import pll_fb_pkg::*;
(
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                start,
	input  wire logic [INT_BITS-1:0] div_int,
	input  wire logic [WORD_W-1:0]   rem,
	input  wire logic [WORD_W-1:0]   den,
	input  wire logic [7:0]          trunc,
	output logic      [RATIO_W-1:0]  ratio,
	output logic                     valid,
	output logic                     busy
);
	// keep bits at or above the truncate position; above 66 keeps none
	function automatic logic [FRAC_BITS-1:0] keep_mask(
		input logic [7:0] tp);
		logic [FRAC_BITS-1:0] m;
		m = '0;
		for (int i = 0; i < FRAC_BITS; i++) begin
			m[i] = (i >= int'(tp));
		end
		return m;
	endfunction

	div_state_t               state;     // sequencer
	logic [WORD_W:0]          part;      // partial remainder
	logic [WORD_W-1:0]        den_q;     // latched denominator
	logic [INT_BITS-1:0]      int_q;     // latched integer part
	logic [7:0]               trunc_q;   // latched truncate position
	logic [FRAC_BITS-1:0]     quo;       // quotient bits
	logic [CNT_W-1:0]         cnt;       // steps left
	logic [WORD_W:0]          shifted;   // partial after shift

	assign shifted = {part[WORD_W-1:0], 1'b0};

	// restoring division, one fractional bit per cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state   <= DIV_IDLE;
			part    <= '0;
			den_q   <= '0;
			int_q   <= '0;
			trunc_q <= '0;
			quo     <= '0;
			cnt     <= '0;
		end else if (start) begin
			// a restart always wins over a run in progress
			state   <= DIV_RUN;
			part    <= {1'b0, rem};
			den_q   <= den;
			int_q   <= div_int;
			trunc_q <= trunc;
			quo     <= '0;
			cnt     <= CNT_W'(FRAC_BITS);
		end else begin
			case (state)
				DIV_RUN: begin
					if (shifted >= {1'b0, den_q}) begin
						part <= shifted - {1'b0, den_q};
						quo  <= {quo[FRAC_BITS-2:0], 1'b1};
					end else begin
						part <= shifted;
						quo  <= {quo[FRAC_BITS-2:0], 1'b0};
					end
					cnt <= cnt - CNT_W'(1);
					if (cnt == CNT_W'(1)) begin
						state <= DIV_DONE;
					end
				end
				default: begin
					state <= state;
				end
			endcase
		end
	end

	// result registers; ratio is zeroed when a run ends on a zero denominator
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ratio <= '0;
			valid <= 1'b0;
			busy  <= 1'b0;
		end else begin
			busy  <= start || (state == DIV_RUN && cnt != CNT_W'(1));
			if (start) begin
				valid <= 1'b0;
			end else if (state == DIV_RUN && cnt == CNT_W'(1)) begin
				valid <= 1'b1;
				// mask applies to the rem/den form
				ratio <= (den_q == '0) ? '0 : {int_q,
					{quo[FRAC_BITS-2:0], shifted >= {1'b0, den_q}}
					& keep_mask(trunc_q)};
			end
		end
	end

endmodule // fb_ratio_divider
`default_nettype wire

// [core/pll_fb_config.sv]
// banked feedback denominator, remainder and truncate registers
//
// Functional notes
// - denominator bytes 2,3 at 2Eh, 2Fh
// - remainder is one 32-bit unsigned word
// - remainder bytes 1..3 at 31h-33h, reset zero
// - 8-bit truncate position at 34h
// - position zero keeps all 66 bits
// - truncation applies only to rem/den form
// - registers banked by the bank select
// - denominator byte 1 at 2Dh, reset zero
`timescale 1ns/1ps
`default_nettype none
module pll_fb_config
	import pll_fb_pkg::*;
(
	input  wire logic hclk,
	input  wire logic hresetn,
	// ahb-lite slave side
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// integer part of the divide value, per bank
	input  wire logic [NUM_BANKS-1:0][INT_BITS-1:0] fb_divide_value,
	// programmed fields, per bank
	output logic [NUM_BANKS-1:0][WORD_W-1:0] fb_denominator,
	output logic [NUM_BANKS-1:0][WORD_W-1:0] fb_remainder,
	output logic [NUM_BANKS-1:0][7:0] fb_truncate_position,
	// effective ratio, integer over fraction
	output logic [NUM_BANKS-1:0][RATIO_W-1:0] fb_ratio,
	output logic [NUM_BANKS-1:0]  fb_ratio_valid
);

	// register map, one byte per word: the denominator sits
	// in indices 2c..2f and the remainder in 30..33, low byte
	// first, so the byte lane of either field is just the two
	// low index bits; the truncate position, bank select and
	// status words follow on their own indices
	// anything outside these indices decodes to no register,
	// which makes writes vanish and reads return zero
	// map a word index onto a register
	function automatic reg_id_t decode_reg(
		input logic [5:0] idx);
		if (idx >= IDX_DEN_B0 && idx <= IDX_DEN_B3) begin
			return REG_DEN;
		end else if (idx >= IDX_REM_B0 && idx <= IDX_REM_B3) begin
			return REG_REM;
		end else if (idx == IDX_TRUNC) begin
			return REG_TRUNC;
		end else if (idx == IDX_BANK) begin
			return REG_BANK;
		end else if (idx == IDX_STATUS) begin
			return REG_STATUS;
		end else begin
			return REG_NONE;
		end
	endfunction

	// byte lane of a multi-byte field; shared by the write
	// paths and the read mux so that both agree on the lane
	// which byte of a multi-byte field
	function automatic logic [1:0] decode_byte(
		input logic [5:0] idx);
		return idx[1:0];
	endfunction

	// state of the bus slave: whether a write or read data
	// phase follows, and what it will touch
	// address phase capture
	logic            acc;        // transfer accepted this edge
	logic            addr_ok;    // upper address bits are zero
	logic            wr_pend;    // write data phase active
	logic            rd_pend;    // read wait state active
	logic [5:0]      idx_q;      // index of the pending access
	reg_id_t         id_q;       // decoded pending register
	logic [1:0]      byte_q;     // decoded pending byte

	// bank select and read path
	logic [BANK_W-1:0] pll_bank_select;   // bank shown to software
	logic [31:0]       rd_mux;            // read value of id_q
	logic [NUM_BANKS-1:0] cfg_start;      // restart per bank
	logic [NUM_BANKS-1:0] div_busy;       // divider running
	logic [NUM_BANKS-1:0][INT_BITS-1:0] last_int;  // seen value

	// only nonseq/seq transfers with hready high
	assign acc = hsel && hready && htrans[1];

	// word aligned, inside the 64-word window
	assign addr_ok = (haddr[31:8] == 24'h00_0000) &&
		(haddr[1:0] == 2'b00);

	// the address phase is captured on the accepting edge;
	// only the index, the decoded register and the byte lane
	// are kept, the rest of haddr is checked and dropped
	// address phase register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			idx_q   <= '0;
			id_q    <= REG_NONE;
			byte_q  <= '0;
		end else begin
			// whole-word writes only; others are dropped
			wr_pend <= acc && hwrite && (hsize == HSIZE_WORD);
			rd_pend <= acc && !hwrite;
			if (acc) begin
				idx_q  <= haddr[7:2];
				// unmapped addresses decode to nothing
				id_q   <= addr_ok ? decode_reg(haddr[7:2])
					: REG_NONE;
				byte_q <= decode_byte(haddr[7:2]);
			end
		end
	end

	// write timing: address phase, then one data phase with
	// hreadyout high, the register lands on the closing edge
	// read timing: address phase, one wait state, then the
	// data phase; the wait state costs a cycle per read but
	// keeps the read mux off the live address bus, which
	// shortens the slowest path from haddr to hrdata
	// ready is pulled low for one cycle on every read so
	// the value is taken after any preceding write landed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
		end else if (acc && !hwrite) begin
			hreadyout <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
		end
	end

	// the slave never stalls a write and never signals an
	// error: refused accesses are dropped silently instead
	// response is always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= HRESP_OKAY;
		end else begin
			hresp <= HRESP_OKAY;
		end
	end

	// the bank select steers every software access to one
	// bank; the outputs below always show both banks, so a
	// change of selection never disturbs a running divider
	// bank select register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pll_bank_select <= RST_BANK;
		end else if (wr_pend && id_q == REG_BANK) begin
			pll_bank_select <= hwdata[BANK_W-1:0];
		end
	end

	// the byte written replaces one lane of the 32-bit field;
	// there is no shadow or atomic update, so software that
	// rewrites a field sees the mixed value until all four
	// bytes are in
	// denominator bytes of the selected bank
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fb_denominator <= '0;
		end else if (wr_pend && id_q == REG_DEN) begin
			// bytes 2 and 3 at 2Eh and 2Fh
			// write lands in the selected bank
			fb_denominator[pll_bank_select][byte_q*8 +: 8]
				<= hwdata[7:0];
		end
	end

	// remainder lanes mirror the denominator lanes exactly,
	// only the base index differs
	// remainder bytes of the selected bank
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fb_remainder <= '0;
		end else if (wr_pend && id_q == REG_REM) begin
			// four bytes, low to high, one word
			// bytes 1..3 at 31h to 33h
			fb_remainder[pll_bank_select][byte_q*8 +: 8]
				<= hwdata[7:0];
		end
	end

	// the position is stored as written; values above the
	// fraction width are not clipped, the divider simply
	// keeps no fractional bit for them
	// truncate position of the selected bank
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fb_truncate_position <= '0;
		end else if (wr_pend && id_q == REG_TRUNC) begin
			fb_truncate_position[pll_bank_select]
				<= hwdata[7:0];
		end
	end

	// the read mux follows the captured index, not haddr, so
	// it settles during the wait state; upper read bits are
	// always zero because every register is one byte wide
	// status is a live view of the selected bank: a poll
	// that sees busy must ask again later, there is no
	// sticky completion flag to clear
	// read value of the pending register
	always_comb begin
		rd_mux = RST_WORD;
		case (id_q)
			REG_DEN: begin
				rd_mux[7:0] = fb_denominator[pll_bank_select]
					[byte_q*8 +: 8];
			end
			REG_REM: begin
				rd_mux[7:0] = fb_remainder[pll_bank_select]
					[byte_q*8 +: 8];
			end
			REG_TRUNC: begin
				rd_mux[7:0] =
					fb_truncate_position[pll_bank_select];
			end
			REG_BANK: begin
				rd_mux[BANK_W-1:0] = pll_bank_select;
			end
			REG_STATUS: begin
				rd_mux[ST_VALID] = fb_ratio_valid[pll_bank_select];
				// zero denominator is flagged, not fixed
				rd_mux[ST_DENZERO] =
					(fb_denominator[pll_bank_select] == '0);
				rd_mux[ST_BUSY] = div_busy[pll_bank_select];
			end
			default: begin
				// unmapped reads give zero
				rd_mux = RST_WORD;
			end
		endcase
	end

	// hrdata keeps its value between reads, so a master that
	// samples it late still sees the last read result
	// read data taken in the wait state, held until next read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= RST_WORD;
		end else if (rd_pend) begin
			hrdata <= rd_mux;
		end
	end

	// the integer part comes from neighbouring logic on the
	// same clock, so no synchroniser is needed; a change of
	// it is treated exactly like a register write
	// integer part seen last, to spot a change
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_int <= '0;
		end else begin
			last_int <= fb_divide_value;
		end
	end

	// every bank has its own divider so a write to one bank
	// never stalls the other; the cost is a second 66-step
	// divider, traded against a shared one with a queue
	// a write to any byte restarts the division, so a field
	// programmed a byte at a time passes through meaningless
	// intermediate ratios: valid stays low until the last
	// write has been quiet for the whole division
	// one divider per bank, restarted on any config change
	generate
		for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
			logic cfg_wr;   // write to this bank's fields

			assign cfg_wr = wr_pend &&
				(pll_bank_select == BANK_W'(b)) &&
				(id_q == REG_DEN || id_q == REG_REM ||
				 id_q == REG_TRUNC);

			// restart one cycle after the field changed
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					cfg_start[b] <= 1'b0;
				end else begin
					cfg_start[b] <= cfg_wr ||
						(fb_divide_value[b] != last_int[b]);
				end
			end

			// ratio from the full assembled words
			fb_ratio_divider u_div (
				.hclk    (hclk),
				.hresetn (hresetn),
				.start   (cfg_start[b]),
				.div_int (fb_divide_value[b]),
				.rem     (fb_remainder[b]),
				.den     (fb_denominator[b]),
				.trunc   (fb_truncate_position[b]),
				.ratio   (fb_ratio[b]),
				.valid   (fb_ratio_valid[b]),
				.busy    (div_busy[b])
			);
		end
	endgenerate

	// the host keeps the programming legal: no zero
	// denominator, zeros below the truncate position and no
	// position above 66; none of it is checked here beyond
	// the status flag, so a bad setting only gives a
	// meaningless ratio, never a hang

endmodule // pll_fb_config
`default_nettype wire

// [tb/pll_fb_config_properties.sv]
// concurrent checks on the feedback divider register slice
`timescale 1ns/1ps
`default_nettype none
module pll_fb_config_properties
	import pll_fb_pkg::*;
(
	input wire logic	hclk,
	input wire logic	hresetn,
	input wire logic	hsel,
	input wire logic [31:0]	haddr,
	input wire logic [1:0]	htrans,
	input wire logic	hwrite,
	input wire logic [2:0]	hsize,
	input wire logic [31:0]	hwdata,
	input wire logic	hready,
	input wire logic	hreadyout,
	input wire logic [31:0]	hrdata,
	input wire logic	hresp,
	input wire logic [NUM_BANKS-1:0][INT_BITS-1:0]	fb_divide_value,
	input wire logic [NUM_BANKS-1:0][WORD_W-1:0]	fb_denominator,
	input wire logic [NUM_BANKS-1:0][WORD_W-1:0]	fb_remainder,
	input wire logic [NUM_BANKS-1:0][7:0]	fb_truncate_position,
	input wire logic [NUM_BANKS-1:0][RATIO_W-1:0]	fb_ratio,
	input wire logic [NUM_BANKS-1:0]	fb_ratio_valid
);
	logic		ap_v, lw_v, bank, lw_bank;	// write tracking
	logic [5:0]	ap_idx, lw_idx;	// word index
	logic [7:0]	lw_dat;	// byte just written
	// valid bits and bank shadow; data regs need no reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_v <= 1'b0;
			lw_v <= 1'b0;
			bank <= RST_BANK;
		end else begin
			// only aligned word writes inside the low page count
			if (hready) begin
				ap_v <= hsel && htrans[1] && hwrite && hsize == HSIZE_WORD
					&& haddr[31:8] == 24'h00_0000 && haddr[1:0] == 2'b00;
			end
			lw_v <= ap_v && hready;
			if (ap_v && hready && ap_idx == IDX_BANK) begin
				bank <= hwdata[0];
			end
		end
	end
	// index, byte and bank of the write ending this cycle
	always_ff @(posedge hclk) begin
		if (hready) begin
			ap_idx <= haddr[7:2];
		end
		lw_idx <= ap_idx;
		lw_dat <= hwdata[7:0];
		lw_bank <= bank;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_den_byte_write: assert property (lw_v && lw_idx inside
		{[IDX_DEN_B1:IDX_DEN_B3]} |-> lw_dat ==
		fb_denominator[lw_bank][8*(lw_idx-IDX_DEN_B0)+:8]) else $error("den byte");
	a_rem_byte_write: assert property (lw_v && lw_idx inside
		{[IDX_REM_B0:IDX_REM_B3]} |-> lw_dat ==
		fb_remainder[lw_bank][8*(lw_idx-IDX_REM_B0)+:8]) else $error("rem byte");
	a_trunc_write: assert property (lw_v && lw_idx == IDX_TRUNC
		|-> fb_truncate_position[lw_bank] == lw_dat) else $error("trunc byte");
	a_bank_isolation: assert property (lw_v && lw_idx == IDX_TRUNC
		|-> $stable(fb_truncate_position[!lw_bank])) else $error("bank leak");
	a_trunc_low_clear: assert property ($rose(fb_ratio_valid[0]) |->
		(fb_ratio[0][FRAC_BITS-1:0] & ((66'h1 << fb_truncate_position[0])
		- 66'h1)) == 66'h0) else $error("low bits set");
	a_ratio_integer: assert property ($rose(fb_ratio_valid[0]) |->
		fb_ratio[0][RATIO_W-1:FRAC_BITS] == fb_divide_value[0])
		else $error("integer part");
	a_ratio_int_b1: assert property ($rose(fb_ratio_valid[1]) |->
		fb_ratio[1][RATIO_W-1:FRAC_BITS] == fb_divide_value[1])
		else $error("bank 1 integer part");
	a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite
		|=> !hreadyout ##1 hreadyout) else $error("read wait state");
	a_resp_okay: assert property (hresp == HRESP_OKAY) else $error("hresp");
endmodule // pll_fb_config_properties
bind pll_fb_config pll_fb_config_properties u_props (.hclk, .hresetn, .hsel,
	.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata,
	.hresp, .fb_divide_value, .fb_denominator, .fb_remainder,
	.fb_truncate_position, .fb_ratio, .fb_ratio_valid);
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the feedback divider register slice
`timescale 1ns/1ps
`default_nettype none
module testbench
	import pll_fb_pkg::*;
;
	logic		hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0]	haddr, hwdata, hrdata;	// bus address and data
	logic [1:0]	htrans;
	logic [2:0]	hsize;
	logic [NUM_BANKS-1:0][INT_BITS-1:0]	divv;	// integer part
	logic [NUM_BANKS-1:0][WORD_W-1:0]	den_o, rem_o;
	logic [NUM_BANKS-1:0][7:0]	trunc_o;
	logic [NUM_BANKS-1:0][RATIO_W-1:0]	ratio_o;
	logic [NUM_BANKS-1:0]	valid_o;
	int		fails, samples_checked;
	int unsigned	seed_val;
	logic [31:0]	rd_q[$];	// expected read data
	logic [RATIO_W-1:0]	ratio_q[$];	// expected ratio
	logic		rd_ph = 1'b0, vprev = 1'b0;	// watcher state
	pll_fb_config uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .fb_divide_value(divv),
		.fb_denominator(den_o), .fb_remainder(rem_o),
		.fb_truncate_position(trunc_o), .fb_ratio(ratio_o),
		.fb_ratio_valid(valid_o));
	// 200 MHz clock
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	task automatic check(input string name, input logic [RATIO_W-1:0] seen,
			input logic [RATIO_W-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict();
		if (fails == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// bounded wait for the slave to sample ready
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			fails++;
			give_verdict();
		end
	endtask
	// one single transfer; for a read d is the expected byte
	task automatic bus(input logic wr, input logic [5:0] idx,
			input logic [31:0] d, input logic [2:0] sz = HSIZE_WORD);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= sz;
		haddr <= {24'h00_0000, idx, 2'b00};
		wait_ready();
		htrans <= 2'b00;
		hsel <= 1'b0;
		if (wr) hwdata <= d;
		else rd_q.push_back(d);
		wait_ready();
	endtask
	// program bank 0 at random, then expect the truncated ratio
	task automatic ratio_case(input logic [7:0] t);
		logic [31:0] den, rem;
		logic [97:0] q;
		logic [INT_BITS-1:0] iv;
		int n;
		// denominator never zero, remainder below it
		den = $urandom | 32'h0000_0100;
		rem = $urandom % den;
		iv = INT_BITS'($urandom);
		// position zero needs rem 0 and den 1
		if (t == 8'h00) begin
			den = 32'h0000_0001;
			rem = 32'h0000_0000;
		end
		// only the integer part is driven, no fraction
		divv <= {INT_BITS'($urandom), iv};
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, 6'(IDX_DEN_B0 + k), {24'h00_0000, den[8*k+:8]});
			bus(1'b1, 6'(IDX_REM_B0 + k), {24'h00_0000, rem[8*k+:8]});
		end
		bus(1'b1, IDX_TRUNC, {24'h00_0000, t});
		q = {rem, 66'h0} / den;
		ratio_q.push_back({iv, q[65:0] & ~((66'h1 << t) - 66'h1)});
		n = 0;
		while (ratio_q.size() > 0 && n < 300) begin
			@(posedge hclk);
			n++;
		end
		if (ratio_q.size() > 0) begin
			fails++;
			give_verdict();
		end
	endtask
	// watcher: read data at the end of each read, ratio on valid rise
	always @(posedge hclk) begin
		if (rd_ph && hreadyout === 1'b1 && rd_q.size() > 0)
			check("hrdata", RATIO_W'(hrdata), RATIO_W'(rd_q.pop_front()));
		if (hreadyout === 1'b1) rd_ph = hsel && htrans[1] && !hwrite;
		if (valid_o[0] === 1'b1 && !vprev && ratio_q.size() > 0)
			check("ratio", ratio_o[0], ratio_q.pop_front());
		vprev = (valid_o[0] === 1'b1);
	end
	// main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0000_0000;
		divv = '0;
		fails = 0;
		samples_checked = 0;
		seed_val = $urandom(57182);
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// bank 1: reset value, then own pattern
		bus(1'b1, IDX_BANK, 32'h0000_0001);
		bus(1'b0, IDX_BANK, 32'h0000_0001);
		for (int i = 0; i < 9; i++) begin
			bus(1'b0, 6'(IDX_DEN_B0 + i), 32'h0000_0000);
			bus(1'b1, 6'(IDX_DEN_B0 + i), 32'(8'ha0 + i));
		end
		// bank 0 untouched, bank 1 kept its pattern
		bus(1'b1, IDX_BANK, 32'h0000_0000);
		for (int i = 0; i < 9; i++) bus(1'b0, 6'(IDX_DEN_B0 + i), 32'h0000_0000);
		bus(1'b1, IDX_BANK, 32'h0000_0001);
		for (int i = 0; i < 9; i++) bus(1'b0, 6'(IDX_DEN_B0 + i), 32'(8'ha0 + i));
		bus(1'b1, IDX_BANK, 32'h0000_0000);
		// refused: byte-size write, unmapped word
		bus(1'b1, IDX_TRUNC, 32'h0000_0055, 3'h0);
		bus(1'b0, IDX_TRUNC, 32'h0000_0000);
		bus(1'b1, 6'h10, 32'h0000_00ff);
		bus(1'b0, 6'h10, 32'h0000_0000);
		// bank 0 never programmed: denominator-zero flag only
		bus(1'b0, IDX_STATUS, 32'h0000_0002);
		// positions at the edges and at random, never above 66
		ratio_case(8'd0);
		ratio_case(8'd42);
		ratio_case(8'd66);
		for (int i = 0; i < 3; i++) ratio_case(8'($urandom_range(65, 1)));
		bus(1'b0, IDX_STATUS, 32'h0000_0001);
		// a restart shows busy with valid low, then settles
		bus(1'b1, IDX_TRUNC, 32'h0000_0042);
		bus(1'b0, IDX_STATUS, 32'h0000_0004);
		repeat (80) @(posedge hclk);
		bus(1'b0, IDX_STATUS, 32'h0000_0001);
		// let the watcher take the last read, then count leftovers
		repeat (2) @(posedge hclk);
		if (rd_q.size() != 0 || ratio_q.size() != 0) fails++;
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
